// File: src/main_oscillator_pll_control.sv
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "osc_ctrl_cfg.svh"

// Behaviour
// - Read-only current source field reports the oscillator now driving the core.
// - New source field uses same codes; reserved 100 falls back to RC.
// - Setting switch bit starts a switch; bit reads zero once complete.
// - Lock bit with monitor option one blocks clock and PLL changes.
// - PLL lock status is one when locked or timer done, PLL running.
// - Monitor failure sets the fail flag; only software clears it.
// - Software writing one to fail flag raises trap, no monitor event.
// - Oscillator control writes take effect only after the unlock sequence.
// - With recovery enabled any interrupt clears doze and forces 1:1.
// - Doze code divides by a power of two, 1 to 128, reset 8.
// - Doze enabled uses the doze ratio; disabled forces ratio 1:1.
// - Writes to the doze ratio are ignored while doze is enabled.
// - Setting doze enable is ignored while the doze ratio is 000.
// - PLL prescaler 4-bit field, codes 1 to 8, reset value 0001.
// - Prescaler changes are accepted while the PLL runs.
// - Reserved and unimplemented bits always read as zero.
// - PLL output equals input times feedback over the three dividers.
module main_oscillator_pll_control
	import osc_ctrl_pkg::*;
(
	// Clock, reset and enable
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic clkEn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Configuration bits, static after power-on
	input wire logic [2:0] strapNewSource,
	input wire logic strapMonitorOption,
	// Oscillator and PLL status pins
	input wire logic pllLockedPin,
	input wire logic pllTimerDonePin,
	input wire logic monitorFailPin,
	input wire logic oscReadyPin,
	// Core side
	input wire logic irqEvent,
	input wire logic [2:0] postDivFirst,
	input wire logic [2:0] postDivSecond,
	// Clock tree controls
	output logic [2:0] oscSelect,
	output logic switchStrobe,
	output logic pllEnable,
	output logic oscFailTrap,
	output logic failSafeEvent,
	output clk_cfg_t clkCfg,
	output logic [31:0] pllOutFreqKhz
);

	// ============================================================
	// Functions
	function automatic logic [2:0] source_fallback(input logic [2:0] code);
		source_fallback = (code == SRC_RESERVED) ? SRC_RC : code;
	endfunction : source_fallback

	function automatic logic is_pll_source(input logic [2:0] code);
		is_pll_source = (code == SRC_RC_PLL) || (code == SRC_PRIMARY_PLL);
	endfunction : is_pll_source

	function automatic logic [31:0] pll_out_khz(input logic [7:0] m,
		input logic [3:0] n1, input logic [2:0] n2, input logic [2:0] n3);
		logic [31:0] den;
		den = 32'(n1) * 32'(n2) * 32'(n3);
		if (den == 32'h0)
			pll_out_khz = 32'h0;
		else
			pll_out_khz = (`PLL_IN_KHZ * 32'(m)) / den;
	endfunction : pll_out_khz

	// ============================================================
	// State
	logic [3:0] syncA_q, syncB_q;
	logic failSeen_q;
	logic strapDone_q;
	logic monitorOption_q;
	logic [2:0] curSource_q, newSource_q, target_q;
	logic switchReq_q, lockEn_q, clockFail_q;
	switch_state_t swState_q;
	logic strobe_q;
	logic roi_q, dozeEn_q;
	logic [2:0] doze_q, rcDiv_q;
	logic [3:0] prescaler_q;
	logic [7:0] feedback_q;
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q;
	logic pllEnable_q, trap_q, fsEvent_q;
	clk_cfg_t clkCfg_q;
	logic [31:0] freq_q;

	logic pllLockedS, timerDoneS, monitorFailS, oscReadyS;
	logic commit, ctlWr, divWr, fbdWr, keyWr, unlocked, cfgLocked;
	logic monitorRise, pllLockStatus, irqRecover;
	logic [2:0] dozeNext;
	logic [31:0] readMux;
	logic addrHit;

	// ============================================================
	// Pin synchronisers; only the second stage is read
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			syncA_q <= 4'h0;
			syncB_q <= 4'h0;
		end
		else if (clkEn)
		begin
			syncA_q <= {oscReadyPin, monitorFailPin, pllTimerDonePin,
				pllLockedPin};
			syncB_q <= syncA_q;
		end
	end

	assign pllLockedS = syncB_q[0];
	assign timerDoneS = syncB_q[1];
	assign monitorFailS = syncB_q[2];
	assign oscReadyS = syncB_q[3];

	// ============================================================
	// APB decode; the answer comes in the first access cycle
	assign commit = psel && penable && pready_q && pwrite && clkEn;
	assign ctlWr = commit && (paddr == `OSC_OFF_CONTROL) && unlocked;
	assign divWr = commit && (paddr == `OSC_OFF_DIVIDER);
	assign fbdWr = commit && (paddr == `OSC_OFF_FEEDBACK);
	assign keyWr = commit && (paddr == `OSC_OFF_UNLOCK);
	assign addrHit = (paddr == `OSC_OFF_CONTROL) || (paddr == `OSC_OFF_DIVIDER)
		|| (paddr == `OSC_OFF_FEEDBACK) || (paddr == `OSC_OFF_UNLOCK);
	assign cfgLocked = lockEn_q && monitorOption_q;
	assign pllLockStatus = pllEnable_q && (pllLockedS || timerDoneS);
	assign monitorRise = monitorFailS && !failSeen_q;
	assign irqRecover = irqEvent && roi_q;

	unlock_sequencer unlock_sequencer_i (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.clkEn(clkEn),
		.keyWrite(keyWr),
		.otherWrite(commit && !keyWr),
		.keyData(pwdata[15:0]),
		.unlocked(unlocked)
	);

	// Read data; unused and reserved bits are tied low
	always_comb
	begin
		readMux = 32'h0;
		case (paddr)
			`OSC_OFF_CONTROL:
			begin
				readMux[`OSC_CUR_LSB +: 3] = curSource_q;
				readMux[`OSC_NEW_LSB +: 3] = newSource_q;
				readMux[`OSC_LOCKEN_BIT] = lockEn_q;
				readMux[`OSC_PLLLOCK_BIT] = pllLockStatus;
				readMux[`OSC_FAIL_BIT] = clockFail_q;
				readMux[`OSC_SWITCH_BIT] = switchReq_q;
			end
			`OSC_OFF_DIVIDER:
			begin
				readMux[`DIV_ROI_BIT] = roi_q;
				readMux[`DIV_DOZE_LSB +: 3] = doze_q;
				readMux[`DIV_DOZE_ENABLE_BIT] = dozeEn_q;
				readMux[`DIV_RCDIV_LSB +: 3] = rcDiv_q;
				readMux[`DIV_PRE_LSB +: 4] = prescaler_q;
			end
			`OSC_OFF_FEEDBACK: readMux[7:0] = feedback_q;
			default: readMux = 32'h0;
		endcase
	end

	// Setup cycle loads the answer so pready is high in the access cycle
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
		end
		else if (clkEn)
		begin
			pready_q <= psel && !penable && !pready_q;
			if (psel && !penable)
			begin
				pslverr_q <= !addrHit;
				prdata_q <= (pwrite || !addrHit) ? 32'h0 : readMux;
			end
			else
				pslverr_q <= 1'b0;
		end
	end

	// ============================================================
	// Strap capture after reset release, then clock switching
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			strapDone_q <= 1'b0;
			monitorOption_q <= 1'b0;
		end
		else if (clkEn && !strapDone_q)
		begin
			strapDone_q <= 1'b1;
			monitorOption_q <= strapMonitorOption;
		end
	end

	// New source and lock bit; with the monitor option set, lock stays until the next reset
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			newSource_q <= SRC_RC;
			lockEn_q <= 1'b0;
		end
		else if (clkEn)
		begin
			if (!strapDone_q)
				newSource_q <= strapNewSource;
			else if (ctlWr && !cfgLocked)
			begin
				newSource_q <= pwdata[`OSC_NEW_LSB +: 3];
				lockEn_q <= pwdata[`OSC_LOCKEN_BIT];
			end
		end
	end

	// Switch handshake: strobe high until the oscillator reports ready,
	// then wait for ready to drop so a stale level never ends a switch
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			swState_q <= SW_IDLE;
			strobe_q <= 1'b0;
			curSource_q <= SRC_RC;
			target_q <= SRC_RC;
			switchReq_q <= 1'b0;
		end
		else if (clkEn)
		begin
			if (!strapDone_q)
			begin
				curSource_q <= source_fallback(strapNewSource);
				target_q <= source_fallback(strapNewSource);
			end
			case (swState_q)
				SW_IDLE:
					if (switchReq_q)
					begin
						target_q <= source_fallback(newSource_q);
						swState_q <= SW_WAIT;
						strobe_q <= 1'b1;
					end
				SW_WAIT:
					if (oscReadyS)
					begin
						curSource_q <= target_q;
						swState_q <= SW_DONE;
						strobe_q <= 1'b0;
					end
				SW_DONE:
					if (!oscReadyS)
						swState_q <= SW_IDLE;
				default:
				begin
					swState_q <= SW_IDLE;
					strobe_q <= 1'b0;
				end
			endcase
			// A software set in the completing cycle wins over the clear
			if (ctlWr && !cfgLocked && pwdata[`OSC_SWITCH_BIT])
				switchReq_q <= 1'b1;
			else if (swState_q == SW_WAIT && oscReadyS)
				switchReq_q <= 1'b0;
		end
	end

	// ============================================================
	// Clock fail flag, trap and monitor event
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			failSeen_q <= 1'b0;
			clockFail_q <= 1'b0;
			trap_q <= 1'b0;
			fsEvent_q <= 1'b0;
		end
		else if (clkEn)
		begin
			failSeen_q <= monitorFailS;
			fsEvent_q <= monitorRise;
			// Set wins over a software clear in the same cycle
			if (monitorRise || (ctlWr && pwdata[`OSC_FAIL_BIT]))
				clockFail_q <= 1'b1;
			else if (ctlWr)
				clockFail_q <= 1'b0;
			trap_q <= monitorRise || (ctlWr && pwdata[`OSC_FAIL_BIT]);
		end
	end

	// ============================================================
	// Clock divider register with doze rules
	assign dozeNext = dozeEn_q ? doze_q : pwdata[`DIV_DOZE_LSB +: 3];

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			roi_q <= 1'b0;
			doze_q <= `DIV_DOZE_RST;
			dozeEn_q <= 1'b0;
			rcDiv_q <= `DIV_RCDIV_RST;
			prescaler_q <= `DIV_PRE_RST;
		end
		else if (clkEn)
		begin
			if (divWr)
			begin
				roi_q <= pwdata[`DIV_ROI_BIT];
				rcDiv_q <= pwdata[`DIV_RCDIV_LSB +: 3];
				doze_q <= dozeNext;
				if (!cfgLocked)
					prescaler_q <= pwdata[`DIV_PRE_LSB +: 4];
			end
			// Interrupt recovery overrides a write in the same cycle
			if (irqRecover)
				dozeEn_q <= 1'b0;
			else if (divWr)
				dozeEn_q <= pwdata[`DIV_DOZE_ENABLE_BIT] && (dozeNext != 3'h0);
		end
	end

	// Feedback divider; range is the software's business
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			feedback_q <= `FBD_VALUE_RST;
		else if (clkEn && fbdWr && !cfgLocked)
			feedback_q <= pwdata[7:0];
	end

	// ============================================================
	// Registered clock tree outputs, one cycle behind the fields
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			clkCfg_q <= '0;
			pllEnable_q <= 1'b0;
			freq_q <= 32'h0;
		end
		else if (clkEn)
		begin
			clkCfg_q.rcDivisor <= (rcDiv_q == 3'h7) ? 9'h100
				: 9'(9'h1 << rcDiv_q);
			clkCfg_q.pllInputPrescaler <= prescaler_q;
			clkCfg_q.pllFeedbackValue <= feedback_q;
			clkCfg_q.cpuDozeRatio <= dozeEn_q ? doze_q : 3'h0;
			clkCfg_q.cpuDivisor <= dozeEn_q ? 8'(8'h1 << doze_q) : 8'h1;
			pllEnable_q <= is_pll_source(curSource_q)
				|| (swState_q != SW_IDLE && is_pll_source(target_q));
			freq_q <= pll_out_khz(feedback_q, prescaler_q, postDivFirst,
				postDivSecond);
		end
	end

	// ============================================================
	// Outputs
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign oscSelect = target_q;
	assign switchStrobe = strobe_q; // Flop mirrors the wait state
	assign pllEnable = pllEnable_q;
	assign oscFailTrap = trap_q;
	assign failSafeEvent = fsEvent_q;
	assign clkCfg = clkCfg_q;
	assign pllOutFreqKhz = freq_q;

	// ============================================================
	// Assertions
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	a_current_src_legal: assert property (
		curSource_q != SRC_RESERVED)
		else $error("current source holds reserved code");

	a_switch_completes: assert property (
		(swState_q == SW_WAIT && oscReadyS && clkEn && !ctlWr)
		|=> (curSource_q == $past(target_q)) && !switchReq_q)
		else $error("switch completion did not update source");

	a_fail_sticky: assert property (
		(clockFail_q && !ctlWr) |=> clockFail_q)
		else $error("fail flag cleared without software");

	a_soft_trap: assert property (
		(ctlWr && pwdata[`OSC_FAIL_BIT] && !monitorRise)
		|=> trap_q && !fsEvent_q && clockFail_q)
		else $error("software fail write handled wrongly");

	a_doze_frozen: assert property (
		(divWr && dozeEn_q) |=> $stable(doze_q))
		else $error("doze ratio changed while doze enabled");

	a_doze_nonzero: assert property (
		dozeEn_q |-> doze_q != 3'h0)
		else $error("doze enabled with zero ratio");

	a_irq_recover: assert property (
		(irqRecover && clkEn) |=> !dozeEn_q ##1 (!clkEn
		|| clkCfg_q.cpuDozeRatio == 3'h0))
		else $error("interrupt did not leave doze");

	a_lock_blocks: assert property (
		(commit && cfgLocked) |=> $stable(newSource_q) && $stable(feedback_q))
		else $error("locked configuration was modified");

	a_pll_status: assert property (
		readMux[`OSC_PLLLOCK_BIT] |-> pllEnable_q)
		else $error("PLL lock reported while disabled");

	a_reserved_zero: assert property (
		pready_q |-> prdata_q[31:16] == 16'h0)
		else $error("reserved read bits not zero");

endmodule : main_oscillator_pll_control
`default_nettype wire

// File: shared/osc_ctrl_cfg.svh
`ifndef OSC_CTRL_CFG_SVH
`define OSC_CTRL_CFG_SVH

// ============================================================
// Register byte offsets on the APB window
`define OSC_OFF_CONTROL 12'h000
`define OSC_OFF_DIVIDER 12'h004
`define OSC_OFF_FEEDBACK 12'h008
`define OSC_OFF_UNLOCK 12'h00c

// ============================================================
// Oscillator control field positions
`define OSC_CUR_LSB 12
`define OSC_NEW_LSB 8
`define OSC_LOCKEN_BIT 7
`define OSC_PLLLOCK_BIT 5
`define OSC_FAIL_BIT 3
`define OSC_SWITCH_BIT 0

// ============================================================
// Clock divider field positions
`define DIV_ROI_BIT 15
`define DIV_DOZE_LSB 12
`define DIV_DOZE_ENABLE_BIT 11
`define DIV_RCDIV_LSB 8
`define DIV_PRE_LSB 0

// ============================================================
// Reset values
`define DIV_DOZE_RST 3'h3
`define DIV_RCDIV_RST 3'h0
`define DIV_PRE_RST 4'h1
`define FBD_VALUE_RST 8'h96

// ============================================================
// Unlock keys, written in this order to the unlock register
`define UNLOCK_KEY_FIRST 16'h00a5
`define UNLOCK_KEY_SECOND 16'h005a

// ============================================================
// Reference input frequency of the PLL in kHz
`define PLL_IN_KHZ 32'd8000

`endif

// File: shared/osc_ctrl_pkg.sv
package osc_ctrl_pkg;

	// ============================================================
	// Oscillator source codes
	typedef enum logic [2:0] {
		SRC_RC = 3'b000,
		SRC_RC_PLL = 3'b001,
		SRC_PRIMARY = 3'b010,
		SRC_PRIMARY_PLL = 3'b011,
		SRC_RESERVED = 3'b100,
		SRC_LOW_POWER_RC = 3'b101,
		SRC_BACKUP_RC = 3'b110,
		SRC_DIVIDED_RC = 3'b111
	} source_t;

	// ============================================================
	// Clock switch handshake states
	typedef enum logic [1:0] {
		SW_IDLE = 2'b00,
		SW_WAIT = 2'b01,
		SW_DONE = 2'b10
	} switch_state_t;

	// ============================================================
	// Unlock sequence states
	typedef enum logic [1:0] {
		UL_IDLE = 2'b00,
		UL_FIRST = 2'b01,
		UL_OPEN = 2'b10
	} unlock_state_t;

	// ============================================================
	// Divider settings handed to the clock tree
	typedef struct packed {
		logic [8:0] rcDivisor;
		logic [3:0] pllInputPrescaler;
		logic [7:0] pllFeedbackValue;
		logic [2:0] cpuDozeRatio;
		logic [7:0] cpuDivisor;
	} clk_cfg_t;

endpackage : osc_ctrl_pkg

// File: src/unlock_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "osc_ctrl_cfg.svh"

module unlock_sequencer
	import osc_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic clkEn,
	// Committed bus writes
	input wire logic keyWrite,
	input wire logic otherWrite,
	input wire logic [15:0] keyData,
	// Write permission for the oscillator control register
	output logic unlocked
);

	unlock_state_t state_q;

	// ============================================================
	// Two keys in a row open one write; any other write closes it
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			state_q <= UL_IDLE;
		else if (clkEn)
		begin
			if (keyWrite)
			begin
				if (keyData == `UNLOCK_KEY_FIRST)
					state_q <= UL_FIRST;
				else if (state_q == UL_FIRST && keyData == `UNLOCK_KEY_SECOND)
					state_q <= UL_OPEN;
				else
					state_q <= UL_IDLE;
			end
			else if (otherWrite)
				state_q <= UL_IDLE; // One write per sequence, then closed
		end
	end

	assign unlocked = (state_q == UL_OPEN);

endmodule : unlock_sequencer
`default_nettype wire

// File: tb/osc_partner_model.sv
`timescale 1ns/1ps
`default_nettype none

module osc_partner_model
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// Answer speed chosen by the bench, in cycles
	input wire logic [3:0] readyDelay,
	// Clock tree controls from the block
	input wire logic switchStrobe,
	input wire logic pllEnable,
	// Source and loop status back to the block
	output logic oscReadyPin,
	output logic pllLockedPin,
	output logic pllTimerDonePin
);
	logic [3:0] waitCnt;
	logic [2:0] lockCnt;

	// ============================================================
	// Source start-up: ready only after the delay, dropped with the strobe
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			waitCnt <= 4'h0;
			oscReadyPin <= 1'b0;
		end
		else if (!switchStrobe)
		begin
			waitCnt <= 4'h0;
			oscReadyPin <= 1'b0;
		end
		else if (waitCnt >= readyDelay)
			oscReadyPin <= 1'b1;
		else
			waitCnt <= waitCnt + 4'h1;
	end

	// ============================================================
	// Loop lock: lock comes early, the start-up timer later; both drop when off
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			lockCnt <= 3'h0;
		else if (!pllEnable)
			lockCnt <= 3'h0;
		else if (lockCnt != 3'h7)
			lockCnt <= lockCnt + 3'h1;
	end
	assign pllLockedPin = pllEnable && (lockCnt >= 3'h3);
	assign pllTimerDonePin = pllEnable && (lockCnt == 3'h7);
endmodule : osc_partner_model

`default_nettype wire

// File: tb/test_main_oscillator_pll_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "osc_ctrl_cfg.svh"

module test_main_oscillator_pll_control;
	// ============================================================
	// Bench signals
	logic clk_sys, resetn, clkEn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, pllOutFreqKhz, clkCfg, rd;
	logic [2:0] strapNewSource, postDivFirst, postDivSecond, oscSelect;
	logic strapMonitorOption, pllLockedPin, pllTimerDonePin, monitorFailPin;
	logic oscReadyPin, irqEvent, switchStrobe, pllEnable, oscFailTrap;
	logic failSafeEvent, isPll;
	logic [3:0] readyDelay, n1;
	logic [2:0] e, p1, p2, rcd;
	logic [7:0] m;
	logic [2:0] codes [9] = '{3'h3, 3'h0, 3'h4, 3'h5, 3'h6, 3'h7, 3'h2, 3'h0, 3'h1};
	int n_errors, comparisons, nTrap, nEvent, n;

	main_oscillator_pll_control main_oscillator_pll_control_i (.clk_sys(clk_sys),
		.resetn(resetn), .clkEn(clkEn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .strapNewSource(strapNewSource),
		.strapMonitorOption(strapMonitorOption), .pllLockedPin(pllLockedPin),
		.pllTimerDonePin(pllTimerDonePin), .monitorFailPin(monitorFailPin),
		.oscReadyPin(oscReadyPin), .irqEvent(irqEvent),
		.postDivFirst(postDivFirst), .postDivSecond(postDivSecond),
		.oscSelect(oscSelect), .switchStrobe(switchStrobe),
		.pllEnable(pllEnable), .oscFailTrap(oscFailTrap),
		.failSafeEvent(failSafeEvent), .clkCfg(clkCfg),
		.pllOutFreqKhz(pllOutFreqKhz));

	osc_partner_model osc_partner_model_i (.clk_sys(clk_sys), .resetn(resetn),
		.readyDelay(readyDelay), .switchStrobe(switchStrobe),
		.pllEnable(pllEnable), .oscReadyPin(oscReadyPin),
		.pllLockedPin(pllLockedPin), .pllTimerDonePin(pllTimerDonePin));

	// ============================================================
	// Clock, pulse counters and watchdog
	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// Count one-cycle pulses so a doubled or missing pulse shows up
	always @(posedge clk_sys)
	begin
		if (oscFailTrap === 1'b1)
			nTrap++;
		if (failSafeEvent === 1'b1)
			nEvent++;
	end

	// Whole run is several hundred cycles; this margin only catches hangs
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		n_errors++;
		tally_and_finish();
	end

	// ============================================================
	// Shared tasks and expectations
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// One transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
		int k;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clk_sys);
			k++;
		end
		while (pready !== 1'b1 && k < 16);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
			chk(32'h0, 32'h1);
	endtask : apb

	// Control writes need the key pair right before them
	task automatic ctl(input logic [15:0] d);
		apb(1'b1, `OSC_OFF_UNLOCK, `UNLOCK_KEY_FIRST);
		apb(1'b1, `OSC_OFF_UNLOCK, `UNLOCK_KEY_SECOND);
		apb(1'b1, `OSC_OFF_CONTROL, d);
	endtask : ctl

	task automatic do_reset(input logic [2:0] s, input logic opt);
		resetn <= 1'b0;
		strapNewSource <= s;
		strapMonitorOption <= opt;
		repeat (10) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (3) @(posedge clk_sys);
	endtask : do_reset

	function automatic logic [8:0] rc_div(input logic [2:0] c);
		return (c == 3'h7) ? 9'd256 : 9'(1 << c);
	endfunction : rc_div

	task automatic tally_and_finish();
		$display("comparisons=%0d mismatches=%0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish

	// ============================================================
	// Main sequence
	initial
	begin
		{resetn, clkEn, psel, penable, pwrite, monitorFailPin, irqEvent} = 7'h20;
		paddr = 12'h000;
		pwdata = 32'h0;
		{postDivFirst, postDivSecond, readyDelay} = {3'h1, 3'h1, 4'h0};
		void'($urandom(97));
		do_reset(3'h7, 1'b0);
		// Reset values, unmapped place, write without keys
		apb(1'b0, `OSC_OFF_CONTROL, 16'h0);
		chk(rd, 32'h7700);
		apb(1'b0, `OSC_OFF_DIVIDER, 16'h0);
		chk(rd, 32'h3001);
		apb(1'b0, `OSC_OFF_FEEDBACK, 16'h0);
		chk(rd, 32'h0096);
		chk(clkCfg, {9'd1, 4'd1, 8'd150, 3'd0, 8'd1});
		apb(1'b0, 12'h010, 16'h0);
		chk({rd[30:0], err}, 32'h1);
		apb(1'b1, `OSC_OFF_CONTROL, 16'h0101);
		apb(1'b0, `OSC_OFF_CONTROL, 16'h0);
		chk(rd, 32'h7700);
		$display("test reset done");
		// Every source code, plain internal RC between the two loop sources
		for (int i = 0; i < 9; i++)
		begin
			readyDelay <= 4'($urandom_range(7, 0));
			e = (codes[i] == 3'h4) ? 3'h0 : codes[i];
			isPll = (e == 3'h1) || (e == 3'h3);
			ctl({5'h0, codes[i], 8'h01});
			n = 0;
			do
			begin
				apb(1'b0, `OSC_OFF_CONTROL, 16'h0);
				n++;
			end
			while ((rd[0] !== 1'b0 || rd[5] !== isPll) && n < 20);
			chk(32'(rd[14:12]), 32'(e));
			chk(32'(rd[0]), 32'h0);
			chk(32'(rd[5]), 32'(isPll));
			chk(32'(oscSelect), 32'(e));
			chk(32'(pllEnable), 32'(isPll));
		end
		$display("test switch done");
		// Loop settings with the loop running, corners first
		for (int i = 0; i < 8; i++)
		begin
			m = (i == 0) ? 8'd200 : (i == 1) ? 8'd16 : 8'($urandom_range(200, 16));
			n1 = (i == 0) ? 4'h8 : 4'($urandom_range(8, 1));
			{p1, p2, rcd} = {3'($urandom_range(7, 1)), 3'($urandom_range(7, 1)), 3'(i)};
			postDivFirst <= p1;
			postDivSecond <= p2;
			apb(1'b1, `OSC_OFF_FEEDBACK, {8'h00, m});
			apb(1'b1, `OSC_OFF_DIVIDER, {5'h0, rcd, 4'h0, n1});
			apb(1'b0, `OSC_OFF_FEEDBACK, 16'h0);
			chk(rd, {24'h0, m});
			apb(1'b0, `OSC_OFF_DIVIDER, 16'h0);
			chk(rd, {21'h0, rcd, 4'h0, n1});
			repeat (4) @(posedge clk_sys);
			chk(clkCfg, {rc_div(rcd), n1, m, 3'd0, 8'd1});
			chk(pllOutFreqKhz, 32'(8000 * m / (n1 * p1 * p2)));
		end
		$display("test loop settings done");
		// Doze: refused enable at 000, every ratio, frozen field, interrupts
		apb(1'b1, `OSC_OFF_DIVIDER, 16'h0801);
		apb(1'b0, `OSC_OFF_DIVIDER, 16'h0);
		chk(rd, 32'h0001);
		for (int d = 1; d < 8; d++)
		begin
			apb(1'b1, `OSC_OFF_DIVIDER, {1'b0, 3'(d), 12'h001});
			apb(1'b1, `OSC_OFF_DIVIDER, {1'b0, 3'(d), 12'h801});
			repeat (3) @(posedge clk_sys);
			chk(32'(clkCfg[10:0]), 32'({3'(d), 8'(1 << d)}));
		end
		apb(1'b1, `OSC_OFF_DIVIDER, 16'h2801);
		irqEvent <= 1'b1;
		@(posedge clk_sys);
		irqEvent <= 1'b0;
		apb(1'b0, `OSC_OFF_DIVIDER, 16'h0);
		chk(rd, 32'h7801);
		apb(1'b1, `OSC_OFF_DIVIDER, 16'hf801);
		irqEvent <= 1'b1;
		@(posedge clk_sys);
		irqEvent <= 1'b0;
		apb(1'b0, `OSC_OFF_DIVIDER, 16'h0);
		chk(rd, 32'hf001);
		chk(32'(clkCfg[10:0]), 32'({3'd0, 8'd1}));
		$display("test doze done");
		// Clock fail: software set traps only, monitor sets both, hardware keeps it
		{nTrap, nEvent} = {32'd0, 32'd0};
		ctl(16'h0008);
		repeat (3) @(posedge clk_sys);
		chk(32'(nTrap), 32'd1);
		chk(32'(nEvent), 32'd0);
		ctl(16'h0000);
		apb(1'b0, `OSC_OFF_CONTROL, 16'h0);
		chk(32'(rd[3]), 32'h0);
		// Clock enable low freezes the synchroniser, so no trap yet
		clkEn <= 1'b0;
		monitorFailPin <= 1'b1;
		repeat (6) @(posedge clk_sys);
		chk(32'(nTrap), 32'd1);
		clkEn <= 1'b1;
		repeat (6) @(posedge clk_sys);
		monitorFailPin <= 1'b0;
		repeat (12) @(posedge clk_sys);
		chk(32'(nTrap), 32'd2);
		chk(32'(nEvent), 32'd1);
		apb(1'b0, `OSC_OFF_CONTROL, 16'h0);
		chk(32'(rd[3]), 32'h1);
		$display("test clock fail done");
		// Locked configuration after a second reset with the option set
		do_reset(3'h2, 1'b1);
		ctl(16'h0280);
		apb(1'b1, `OSC_OFF_DIVIDER, 16'h3004);
		apb(1'b1, `OSC_OFF_FEEDBACK, 16'h0032);
		ctl(16'h0501);
		apb(1'b0, `OSC_OFF_DIVIDER, 16'h0);
		chk(rd, 32'h3001);
		apb(1'b0, `OSC_OFF_FEEDBACK, 16'h0);
		chk(rd, 32'h0096);
		apb(1'b0, `OSC_OFF_CONTROL, 16'h0);
		chk(rd, 32'h2280);
		$display("test config lock done");
		tally_and_finish();
	end
endmodule : test_main_oscillator_pll_control

`default_nettype wire
